// *** iwa_pkg.sv ***
package iwa_pkg;

  // timing of the locally generated serial clock
  localparam int          SYS_CLK_NS   = 10;   // sys_clk_i period
  localparam int          SCL_HALF_NS  = 80;   // half period of the master clock
  // least time, so rounded up to whole cycles
  localparam logic [7:0]  SCL_HALF_CYC = 8'((SCL_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);

  // clock counts inside one byte (clocks completed since the byte began)
  localparam logic [3:0]  CNT_LAST_BIT = 4'h7; // falling edge of clock 8 follows
  localparam logic [3:0]  CNT_ACK      = 4'h8; // falling edge of clock 9 follows

  // extension codes: upper four address bits
  localparam logic [3:0]  EXT_UPPER_LO = 4'h0;
  localparam logic [3:0]  EXT_UPPER_HI = 4'hf;

  // receive buffer shape
  localparam int          BUF_WIDTH    = 8;
  localparam int          BUF_DEPTH    = 2;

  // control bits from software; release and request bits are one-cycle pulses
  typedef struct packed {
    logic enable;
    logic bus_release_bit;
    logic wait_release_bit;
    logic stop_irq_enable;
    logic wait_timing_sel;
    logic ack_enable_bit;
    logic start_request_bit;
    logic stop_request_bit;
  } iwa_ctrl_t;

  // status seen by software, bit 7 down to bit 0
  typedef struct packed {
    logic master;
    logic arbitration_lost_flag;
    logic extension_code_flag;
    logic address_match_flag;
    logic transmit;
    logic ack_detected;
    logic start_detected_flag;
    logic stop_detected;
  } iwa_status_t;

  localparam iwa_status_t STATUS_RST = '0;

  typedef enum logic [2:0] {
    MS_IDLE,
    MS_START,
    MS_LOW,
    MS_HIGH,
    MS_RS_HIGH,
    MS_STOP_LOW,
    MS_STOP_HIGH
  } iwa_mst_t;

endpackage

// *** iwa_sync.sv ***
`timescale 1ns/1ps
module iwa_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] level_o,
  output logic      [WIDTH-1:0] rise_o,
  output logic      [WIDTH-1:0] fall_o
);

  // one two-flop synchroniser plus edge delay per line
  for (genvar g = 0; g < WIDTH; g++) begin : g_line
    logic meta;   // first stage, read only by the second
    logic sync;   // safe level
    logic dly;    // previous safe level, for edges

    // lines idle high, so reset to one to avoid a false edge
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        meta <= 1'b1;
        sync <= 1'b1;
        dly  <= 1'b1;
      end else begin
        meta <= async_i[g];
        sync <= meta;
        dly  <= sync;
      end
    end

    assign level_o[g] = sync;
    assign rise_o[g]  = sync & ~dly;
    assign fall_o[g]  = ~sync & dly;
  end

endmodule

// *** iwa_buf.sv ***
`timescale 1ns/1ps
module iwa_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL_CNT = (PW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];  // flip-flop storage
  logic [PW-1:0]    wr_ptr;       // next entry to fill
  logic [PW-1:0]    rd_ptr;       // oldest entry
  logic [PW:0]      fill;         // entries held
  logic             push;
  logic             pop;

  assign in_ready_o  = (fill != FULL_CNT);
  assign out_valid_o = (fill != '0);
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign out_data_o  = mem[rd_ptr];

  // storage carries no reset; only valid entries are ever shown
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
      end
      if (push && !pop) begin
        fill <= fill + (PW + 1)'(1);
      end else if (pop && !push) begin
        fill <= fill - (PW + 1)'(1);
      end
    end
  end

endmodule

// *** iwa_core.sv ***
`timescale 1ns/1ps
module iwa_core
  import iwa_pkg::*;
(
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_n_i,
  input  wire iwa_ctrl_t            bus_control_reg_i,
  input  wire logic [6:0]           own_address_reg_i,
  input  wire logic                 shift_wr_i,
  input  wire logic [7:0]           shift_wdata_i,
  input  wire logic                 status_clr_i,
  output iwa_status_t               bus_status_reg_o,
  output logic                      tx_error_o,
  output logic [7:0]                shift_reg_o,
  output logic                      waiting_o,
  output logic                      serial_bus_irq_o,
  output logic [BUF_WIDTH-1:0]      rx_data_o,
  output logic                      rx_valid_o,
  input  wire logic                 rx_ready_i,
  input  wire logic                 serial_clock_line_i,
  output logic                      serial_clock_line_o,
  output logic                      serial_clock_line_oe_n_o,
  input  wire logic                 serial_data_line_i,
  output logic                      serial_data_line_o,
  output logic                      serial_data_line_oe_n_o
);

  iwa_ctrl_t   ctl;           // control bits, short name
  iwa_status_t st;            // status register
  logic        is_master;     // we drive the clock as master
  logic        is_transmit;   // we drive the data bits
  logic        arb_lost;      // arbitration lost, until cleared
  logic        ext_flag;      // extension code received
  logic        match_flag;    // own address received
  logic        ack_seen;      // acknowledge seen on clock 9
  logic        start_seen;    // last condition was a start
  logic        stop_seen;     // last condition was a stop
  iwa_mst_t    ms;            // master clock generator state
  logic [1:0]  lvl, rise, fall;
  logic        scl_s, sda_s, scl_r, scl_f, sda_r, sda_f;
  logic        start_det;     // start or restart seen on the bus
  logic        stop_det;      // stop seen on the bus
  logic [7:0]  shift_reg;     // shift register, both directions
  logic [7:0]  tx_byte;       // byte as written, for error compare
  logic        tx_error;      // captured byte differed from sent byte
  logic        out_bit;       // bit on the data line, changes only with clock low
  logic [3:0]  cnt;           // clocks completed in this byte
  logic        first_fall;    // next fall is the start's own fall
  logic        addr_phase;    // first byte after a start
  logic        bus_busy;      // between start and stop
  logic        restart;       // this start came without a stop
  logic        prev_sel;      // we took part before the restart
  logic        selected;      // we take part in the data phase
  logic        lost_pending;  // loss still owes its interrupt
  logic        waiting;       // clock held low for software
  logic        push_pending;  // received byte waits for buffer room
  logic [7:0]  rx_hold;       // byte offered to the buffer
  logic        buf_ready;
  logic [7:0]  tmr;           // half period timer
  logic        fall8, fall9, bit_rise, ack_rise;
  logic        ext_now, match_now, lose_evt, release_evt, hold;
  logic        irq_evt, wait_evt, start_wait;
  logic        scl_drive, sda_drive, tx_drive, ack_drive;

  assign ctl = bus_control_reg_i;

  // status fields live in separate flops so each has one writing process
  assign st = iwa_status_t'({is_master, arb_lost, ext_flag, match_flag,
                             is_transmit, ack_seen, start_seen, stop_seen});

  // both lines come from outside the clock domain
  iwa_sync #(.WIDTH(2)) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   ({serial_data_line_i, serial_clock_line_i}),
    .level_o   (lvl),
    .rise_o    (rise),
    .fall_o    (fall)
  );

  assign scl_s = lvl[0];
  assign sda_s = lvl[1];
  assign scl_r = rise[0];
  assign scl_f = fall[0];
  assign sda_r = rise[1];
  assign sda_f = fall[1];

  // bus conditions: data edge while clock high
  assign start_det = sda_f & scl_s;
  assign stop_det  = sda_r & scl_s;

  // byte position events, the start's own fall excluded
  assign fall8    = scl_f & ~first_fall & (cnt == CNT_LAST_BIT);
  assign fall9    = scl_f & ~first_fall & (cnt == CNT_ACK);
  assign bit_rise = scl_r & ~first_fall & (cnt < CNT_ACK);
  assign ack_rise = scl_r & ~first_fall & (cnt == CNT_ACK);

  // address decode on the byte just completed
  assign ext_now   = (shift_reg[7:4] == EXT_UPPER_LO) |
                     (shift_reg[7:4] == EXT_UPPER_HI);
  assign match_now = (shift_reg[7:1] == own_address_reg_i);

  // lost when we released the data line and someone held it low,
  // or a foreign stop or restart cut into our transfer
  assign lose_evt = st.master & (
                      (bit_rise & st.transmit & out_bit & ~sda_s) |
                      (stop_det & (ms != MS_STOP_HIGH)) |
                      (start_det & (ms != MS_START)));

  // wait release: master-only requests are ignored as a slave
  assign release_evt = ctl.wait_release_bit | shift_wr_i |
                       (st.master & (ctl.start_request_bit | ctl.stop_request_bit));
  assign hold        = waiting | push_pending;
  assign start_wait  = (ms == MS_START) & (tmr == '0);

  // interrupt and wait decisions, one per bus event
  always_comb begin
    irq_evt  = 1'b0;
    wait_evt = 1'b0;
    if (fall8) begin
      if (addr_phase) begin
        if (ext_now && !st.master) begin
          irq_evt  = 1'b1;
          wait_evt = ~lost_pending | match_now;
        end
      end else if (selected && !ctl.wait_timing_sel) begin
        irq_evt  = 1'b1;
        wait_evt = 1'b1;
      end else if (lost_pending && !ctl.wait_timing_sel) begin
        irq_evt  = 1'b1;
      end
    end
    if (fall9) begin
      if (addr_phase) begin
        if (st.master) begin
          irq_evt  = 1'b1;
          wait_evt = 1'b1;
        end else if (st.address_match_flag && !st.extension_code_flag) begin
          irq_evt  = 1'b1;
          wait_evt = 1'b1;
        end else if (st.extension_code_flag) begin
          irq_evt  = lost_pending & ctl.wait_timing_sel;
        end else if (lost_pending) begin
          irq_evt  = 1'b1;
        end else if (restart && prev_sel) begin
          irq_evt  = 1'b1;
        end
        // otherwise no interrupt and no wait
      end else if (selected && ctl.wait_timing_sel) begin
        irq_evt  = 1'b1;
        wait_evt = 1'b1;
      end else if (lost_pending && ctl.wait_timing_sel) begin
        irq_evt  = 1'b1;
      end
    end
    if (stop_det && ctl.stop_irq_enable) begin
      irq_evt = 1'b1;
    end
  end

  // shift register: load on write, sample on rise
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_reg <= 8'h00;
      tx_byte   <= 8'h00;
      out_bit   <= 1'b1;
    end else begin
      if (shift_wr_i) begin
        shift_reg <= shift_wdata_i;
        tx_byte   <= shift_wdata_i;
        out_bit   <= shift_wdata_i[7];
      end else begin
        if (bit_rise) begin
          shift_reg <= {shift_reg[6:0], sda_s};
        end
        // next bit only while the clock is low, msb first
        if (scl_f && (first_fall || cnt < CNT_LAST_BIT || cnt == CNT_ACK)) begin
          out_bit <= shift_reg[7];
        end
      end
    end
  end

  // byte framing: clock count and address phase
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt        <= 4'h0;
      first_fall <= 1'b0;
      addr_phase <= 1'b0;
      bus_busy   <= 1'b0;
      restart    <= 1'b0;
      prev_sel   <= 1'b0;
    end else if (start_det) begin
      cnt        <= 4'h0;
      first_fall <= 1'b1;
      addr_phase <= 1'b1;
      bus_busy   <= 1'b1;
      restart    <= bus_busy;
      prev_sel   <= selected | st.master;
    end else if (stop_det) begin
      addr_phase <= 1'b0;
      bus_busy   <= 1'b0;
      restart    <= 1'b0;
    end else if (scl_f) begin
      if (first_fall) begin
        first_fall <= 1'b0;
      end else if (cnt == CNT_ACK) begin
        cnt        <= 4'h0;
        addr_phase <= 1'b0;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end

  // role tracking: master, selected slave, direction
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      is_master    <= STATUS_RST.master;
      is_transmit  <= STATUS_RST.transmit;
      selected     <= 1'b0;
      lost_pending <= 1'b0;
    end else begin
      if (lose_evt || !ctl.enable) begin
        is_master    <= 1'b0;
        is_transmit  <= 1'b0;
        selected     <= 1'b0;
        lost_pending <= ctl.enable & ~stop_det;
      end else if (stop_det || ctl.bus_release_bit) begin
        is_master    <= st.master & ~stop_det;
        is_transmit  <= 1'b0;
        selected     <= 1'b0;
        lost_pending <= 1'b0;
      end else if (ms == MS_IDLE && ctl.start_request_bit && !bus_busy) begin
        is_master   <= 1'b1;
        is_transmit <= 1'b1;
      end else if (start_det) begin
        is_transmit <= st.master;
        selected    <= 1'b0;
      end else begin
        if (irq_evt) begin
          lost_pending <= 1'b0;
        end
        if (fall8 && addr_phase && ext_now && !st.master) begin
          selected <= 1'b1;
        end
        if (fall9 && addr_phase) begin
          selected <= st.master | st.address_match_flag | (selected & st.extension_code_flag);
          if (st.master) begin
            is_transmit <= ~shift_reg[0];
          end else if (st.address_match_flag) begin
            is_transmit <= shift_reg[0];
          end
        end
      end
    end
  end

  // flags set by bus events; the set wins over a software clear, except the bus release bit clears the address flags first
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      arb_lost   <= STATUS_RST.arbitration_lost_flag;
      ext_flag   <= STATUS_RST.extension_code_flag;
      match_flag <= STATUS_RST.address_match_flag;
      ack_seen   <= STATUS_RST.ack_detected;
      start_seen <= STATUS_RST.start_detected_flag;
      stop_seen  <= STATUS_RST.stop_detected;
      tx_error   <= 1'b0;
    end else begin
      if (lose_evt) begin
        arb_lost <= 1'b1;
      end else if (status_clr_i) begin
        arb_lost <= 1'b0;
      end
      if (fall8 && st.transmit && shift_reg != tx_byte) begin
        tx_error <= 1'b1;
      end else if (status_clr_i || shift_wr_i) begin
        tx_error <= 1'b0;
      end
      if (start_det || stop_det || ctl.bus_release_bit) begin
        ext_flag   <= 1'b0;
        match_flag <= 1'b0;
      end else if (fall8 && addr_phase) begin
        ext_flag   <= ext_now;
        match_flag <= match_now;
      end
      if (ack_rise) begin
        ack_seen <= ~sda_s;
      end
      if (start_det) begin
        start_seen <= 1'b1;
        stop_seen  <= 1'b0;
      end else if (stop_det) begin
        start_seen <= 1'b0;
        stop_seen  <= 1'b1;
      end
    end
  end

  // wait hold: a new wait in the same cycle as a release wins
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      waiting <= 1'b0;
    end else if (wait_evt || start_wait) begin
      waiting <= 1'b1;
    end else if (release_evt || stop_det || lose_evt || ctl.bus_release_bit) begin
      waiting <= 1'b0;
    end
  end

  // received data byte goes to the buffer; a full buffer stretches the clock
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      push_pending <= 1'b0;
      rx_hold      <= 8'h00;
    end else if (fall8 && !addr_phase && selected && !st.transmit) begin
      push_pending <= 1'b1;
      rx_hold      <= shift_reg;
    end else if (buf_ready || stop_det || start_det) begin
      push_pending <= 1'b0;
    end
  end

  iwa_buf #(.WIDTH(BUF_WIDTH), .DEPTH(BUF_DEPTH)) u_rx_buf (
    .sys_clk_i   (sys_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (push_pending),
    .in_ready_o  (buf_ready),
    .in_data_i   (rx_hold),
    .out_valid_o (rx_valid_o),
    .out_ready_i (rx_ready_i),
    .out_data_o  (rx_data_o)
  );

  // master clock generator; clock high phase waits for the line to rise
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ms  <= MS_IDLE;
      tmr <= 8'h00;
    end else if (lose_evt || !ctl.enable) begin
      ms <= MS_IDLE;
    end else begin
      unique case (ms)
        MS_IDLE: begin
          // a request before a foreign start is seen still starts
          if (ctl.start_request_bit && !bus_busy) begin
            ms  <= MS_START;
            tmr <= SCL_HALF_CYC;
          end
        end
        MS_START: begin
          if (tmr != 8'h00) begin
            tmr <= tmr - 8'h01;
          end else begin
            ms  <= MS_LOW;
            tmr <= SCL_HALF_CYC;
          end
        end
        MS_LOW: begin
          if (waiting && ctl.start_request_bit) begin
            ms  <= MS_RS_HIGH;
            tmr <= SCL_HALF_CYC;
          end else if (waiting && ctl.stop_request_bit) begin
            ms  <= MS_STOP_LOW;
            tmr <= SCL_HALF_CYC;
          end else if (hold) begin
            tmr <= SCL_HALF_CYC;
          end else if (tmr != 8'h00) begin
            tmr <= tmr - 8'h01;
          end else begin
            ms  <= MS_HIGH;
            tmr <= SCL_HALF_CYC;
          end
        end
        MS_HIGH, MS_RS_HIGH, MS_STOP_HIGH: begin
          // another device stretching keeps the timer frozen
          if (scl_s && tmr != 8'h00) begin
            tmr <= tmr - 8'h01;
          end else if (scl_s) begin
            tmr <= SCL_HALF_CYC;
            ms  <= (ms == MS_HIGH) ? MS_LOW : (ms == MS_RS_HIGH) ? MS_START : MS_IDLE;
          end
        end
        MS_STOP_LOW: begin
          if (tmr != 8'h00) begin
            tmr <= tmr - 8'h01;
          end else begin
            ms  <= MS_STOP_HIGH;
            tmr <= SCL_HALF_CYC;
          end
        end
      endcase
    end
  end

  // line drive; acknowledge read live so software may set it during the wait
  assign tx_drive  = st.transmit & (cnt < CNT_ACK) & ~out_bit & (ms != MS_RS_HIGH);
  assign ack_drive = ~first_fall & (cnt == CNT_ACK) & ~st.transmit & (ms != MS_RS_HIGH) &
                     (addr_phase ? (st.address_match_flag |
                                    (st.extension_code_flag & ctl.ack_enable_bit))
                                 : (selected & ctl.ack_enable_bit));
  assign scl_drive = (ms == MS_LOW) | (ms == MS_STOP_LOW) | hold;
  assign sda_drive = (ms == MS_START) | (ms == MS_STOP_LOW) | (ms == MS_STOP_HIGH) |
                     tx_drive | ack_drive;

  // registered pins and interrupt pulse; loss releases both lines at once
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      serial_clock_line_oe_n_o <= 1'b1;
      serial_data_line_oe_n_o  <= 1'b1;
      serial_bus_irq_o         <= 1'b0;
    end else begin
      serial_clock_line_oe_n_o <= ~(scl_drive & ~lose_evt & ctl.enable);
      serial_data_line_oe_n_o  <= ~(sda_drive & ~lose_evt & ctl.enable);
      serial_bus_irq_o         <= irq_evt;
    end
  end

  assign serial_clock_line_o = 1'b0;
  assign serial_data_line_o  = 1'b0;
  assign bus_status_reg_o    = st;
  assign tx_error_o          = tx_error;
  assign shift_reg_o         = shift_reg;
  assign waiting_o           = waiting;

endmodule

// *** iwa_core_chk.sv ***
`timescale 1ns/1ps
module iwa_core_chk
  import iwa_pkg::*;
(
  input wire logic                 sys_clk_i,
  input wire logic                 rst_n_i,
  input wire iwa_ctrl_t            bus_control_reg_i,
  input wire logic                 shift_wr_i,
  input wire iwa_status_t          bus_status_reg_o,
  input wire logic                 waiting_o,
  input wire logic                 serial_bus_irq_o,
  input wire logic [BUF_WIDTH-1:0] rx_data_o,
  input wire logic                 rx_valid_o,
  input wire logic                 rx_ready_i,
  input wire logic                 serial_clock_line_oe_n_o,
  input wire logic                 serial_data_line_oe_n_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // a standing wait keeps the clock pulled low
  a_wait_holds_scl: assert property (waiting_o && $past(waiting_o) |-> !serial_clock_line_oe_n_o)
    else $error("wait without clock hold");
  a_release_ends_wait: assert property (waiting_o && bus_control_reg_i.wait_release_bit |=> !waiting_o)
    else $error("release bit left wait");
  a_write_ends_wait: assert property (waiting_o && shift_wr_i |=> !waiting_o)
    else $error("shift write left wait");
  a_loss_frees_bus: assert property ($rose(bus_status_reg_o.arbitration_lost_flag)
    |-> ##[0:1] (serial_clock_line_oe_n_o && serial_data_line_oe_n_o))
    else $error("lines held after loss");
  a_stop_irq_on: assert property ($rose(bus_status_reg_o.stop_detected)
    && bus_control_reg_i.stop_irq_enable |-> ##[0:1] serial_bus_irq_o)
    else $error("stop irq missing");
  a_stop_irq_off: assert property ($rose(bus_status_reg_o.stop_detected)
    && !bus_control_reg_i.stop_irq_enable |-> !serial_bus_irq_o [*2])
    else $error("stop irq not gated");
  a_slave_wait_irq: assert property ($rose(waiting_o) && !bus_status_reg_o.master
    |-> serial_bus_irq_o || $past(serial_bus_irq_o))
    else $error("slave wait without irq");
  // a stalled consumer must not lose or change the head word
  a_rx_hold_word: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o))
    else $error("rx word lost");
  c_irq: cover property (serial_bus_irq_o);
  c_match: cover property ($rose(bus_status_reg_o.address_match_flag));
  c_ext: cover property ($rose(bus_status_reg_o.extension_code_flag));
endmodule

// *** iwa_bus_master.sv ***
`timescale 1ns/1ps
module iwa_bus_master (
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_n_o,
  output logic      sda_n_o
);
  int clk_n;  // clocks finished in the current byte
  initial begin
    scl_n_o = 1;
    sda_n_o = 1;
    clk_n = 0;
  end
  // start: data falls while clock is high
  task automatic start();
    sda_n_o = 0;
    #80 scl_n_o = 0;
    clk_n = 0;
  endtask
  // data moves well after the fall so no false start or stop is seen
  task automatic bit_io(input logic b, output logic r);
    #20 sda_n_o = b;
    #60 scl_n_o = 1;
    wait (scl_i);  // the slave may stretch the low phase
    #80 r = sda_i;
    scl_n_o = 0;
    // count restarts at each byte, but holds 9 until the next clock ends
    clk_n = (clk_n == 9) ? 1 : clk_n + 1;
  endtask
  // eight bits msb first, then the acknowledge clock
  task automatic tx(input logic [7:0] d, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, a);
  endtask
  task automatic stop();
    #20 sda_n_o = 0;
    #60 scl_n_o = 1;
    wait (scl_i);
    #80 sda_n_o = 1;
    clk_n = 0;
    #80;
  endtask
endmodule

// *** tb_i2c_event_wait_arbitration.sv ***
`timescale 1ns/1ps
module tb_i2c_event_wait_arbitration;
  import iwa_pkg::*;
  logic        sys_clk_i = 0, rst_n_i = 0, rx_ready_i = 1, rel = 0, sw = 0, ack, wt, irq, rv;
  logic        clr = 0, txe;
  logic [6:0]  own = 7'h2a;
  logic [7:0]  wdat = 8'h00;
  logic        scl_n, sda_n, m_scl_n, m_sda_n, scl, sda;
  logic [7:0]  cfg = 8'h80, rxd, d;
  logic [31:0] seed = 32'h48;
  iwa_status_t st;
  iwa_ctrl_t   ctl;
  int          err_count = 0, samples_checked = 0;
  logic [7:0]  exp_q[$], rx_q[$];
  assign ctl = iwa_ctrl_t'({cfg[7:6], rel, cfg[4:0]});
  assign scl = scl_n & m_scl_n;  // wired and with pull-up
  assign sda = sda_n & m_sda_n;
  always #5 sys_clk_i = ~sys_clk_i;
  iwa_core dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .bus_control_reg_i(ctl),
    .own_address_reg_i(own), .shift_wr_i(sw), .shift_wdata_i(wdat), .status_clr_i(clr),
    .bus_status_reg_o(st), .tx_error_o(txe), .shift_reg_o(), .waiting_o(wt),
    .serial_bus_irq_o(irq), .rx_data_o(rxd), .rx_valid_o(rv), .rx_ready_i(rx_ready_i),
    .serial_clock_line_i(scl), .serial_clock_line_o(), .serial_clock_line_oe_n_o(scl_n),
    .serial_data_line_i(sda), .serial_data_line_o(), .serial_data_line_oe_n_o(sda_n));
  iwa_bus_master bm (.scl_i(scl), .sda_i(sda), .scl_n_o(m_scl_n), .sda_n_o(m_sda_n));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // software side: random stalls, waits freed by release bit or shift write
  always @(negedge sys_clk_i) begin
    seed <= xs(seed);
    rx_ready_i <= seed[0];
    wdat <= seed[23:16];
    clr <= seed[2];
    rel <= wt & ~seed[1] & ~rel & ~sw;
    sw <= wt & seed[1] & ~rel & ~sw;
    if (irq) chk("irq_clock", 8'(bm.clk_n), exp_q.size() ? exp_q.pop_front() : 8'hxx);
    if (irq) chk("lost_at_irq", st.arbitration_lost_flag, 0);
    // seed[0] is the ready level the design samples at the coming edge
    if (rv & seed[0]) chk("rx_data", rxd, rx_q.size() ? rx_q.pop_front() : 8'hxx);
  end
  task end_sim;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #400_000 err_count++;
    end_sim;
  end
  initial begin
    repeat (4) @(posedge sys_clk_i);
    @(negedge sys_clk_i) rst_n_i = 1;
    for (int w = 0; w < 2; w++) begin
      cfg[4:3] = {2{w[0]}};
      bm.start();
      exp_q.push_back(9);
      bm.tx(8'h54, ack);
      chk("own_ack", ack, 0);
      d = seed[15:8];
      rx_q.push_back(d);
      exp_q.push_back(w ? 9 : 8);
      bm.tx(d, ack);
      if (w) exp_q.push_back(0);
      bm.stop();
      bm.start();
      bm.tx(8'h56, ack);
      chk("foreign_ack", ack, 1);
      if (w) exp_q.push_back(0);
      bm.stop();
      bm.start();
      exp_q.push_back(8);
      bm.tx(8'h00, ack);
      chk("ext_flag", st.extension_code_flag, 1);
      @(negedge sys_clk_i) cfg[6] = 1;
      @(negedge sys_clk_i) cfg[6] = 0;
      @(negedge sys_clk_i) chk("standby", st.extension_code_flag, 0);
      if (w) exp_q.push_back(0);
      bm.stop();
      repeat (30) @(negedge sys_clk_i);
    end
    chk("irq_left", 8'(exp_q.size()), 0);
    chk("rx_left", 8'(rx_q.size()), 0);
    chk("tx_error", txe, 0);
    end_sim;
  end
endmodule
bind iwa_core iwa_core_chk chk (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
  .bus_control_reg_i(bus_control_reg_i), .shift_wr_i(shift_wr_i),
  .bus_status_reg_o(bus_status_reg_o), .waiting_o(waiting_o),
  .serial_bus_irq_o(serial_bus_irq_o), .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o),
  .rx_ready_i(rx_ready_i), .serial_clock_line_oe_n_o(serial_clock_line_oe_n_o),
  .serial_data_line_oe_n_o(serial_data_line_oe_n_o));
